/* File: rtl/bridge_params.svh */
// Constants for the host bus to microcontroller bridge.
// Assumes inclusion by bare name from rtl/ files only.
`ifndef BRIDGE_PARAMS_SVH
`define BRIDGE_PARAMS_SVH
`define REG_CSW 3'h0
`define REG_RXPORT 3'h2
`define REG_TER 3'h4
`define REG_TXPORT 3'h6
`define REG_TCW 3'h4
`define REG_TDW 3'h6
`define REG_MSW 3'h6
`define TOP_BITS 5'h1f
`define RX_W 16
`define RX_DEPTH 64
`define RX_AW 6
`define LC_W 24
`define LC_DEPTH 64
`define LC_AW 6
`define ALARM_COUNT 5'h10
`define CSW_DONE_BIT 7
`define CSW_RIE_BIT 6
`define CSW_SAE_BIT 12
`define CSW_TIE_BIT 14
`define CSW_TRANSMIT_READY_FLAG_BIT 15
`define CSW_ALARM_BIT 13
`define VEC_STEP 9'h004
`endif

/* File: rtl/bridge_pkg.sv */
// Types shared by the bridge files.
// Assumes bridge_params.svh is on the include path.
package bridge_pkg;
	// One host bus slave cycle as seen after address decode
	typedef struct packed {
		logic sel;
		logic write;
		logic byte_op;
		logic hi_byte;
		logic [2:0] reg_idx;
		logic [15:0] wdata;
	} host_req_t;
	// Receive entry layout
	typedef struct packed {
		logic unused;
		logic err;
		logic framing;
		logic overrun;
		logic parity;
		logic [2:0] line;
		logic [7:0] char_data;
	} rx_entry_t;
	typedef enum logic [1:0] {ARB_IDLE, ARB_RX, ARB_TX} arb_state_t;
endpackage

/* File: rtl/sync_fifo.sv */
// Flip-flop FIFO with empty and full flags for the bridge queues.
// Assumes one clock; both sides are strobes in that clock.
`timescale 1ns/1ps
`include "bridge_params.svh"
module sync_fifo #(
	parameter int W = 16,
	parameter int AW = 6
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic reset,
	// Fill side
	input wire logic wr_en,
	input wire logic [W-1:0] wr_data,
	// Drain side
	input wire logic rd_en,
	output logic [W-1:0] rd_data,
	// Flags
	output logic empty,
	output logic full
);
	typedef struct packed {
		logic [AW:0] wp;
		logic [AW:0] rp;
	} ptr_t;
	ptr_t st_q, st_d;
	logic [W-1:0] mem_q [(1<<AW)];
	logic do_wr;
	logic do_rd;
	// Full writes dropped, empty reads ignored
	assign empty = (st_q.wp == st_q.rp);
	assign full = (st_q.wp[AW-1:0] == st_q.rp[AW-1:0]) && (st_q.wp[AW] != st_q.rp[AW]);
	assign do_wr = wr_en && !full;
	assign do_rd = rd_en && !empty;
	assign rd_data = mem_q[st_q.rp[AW-1:0]];
	// Pointer update
	always_comb
	begin
		st_d = st_q;
		if (do_wr)
			st_d.wp = st_q.wp + 1'b1;
		if (do_rd)
			st_d.rp = st_q.rp + 1'b1;
	end
	always_ff @(posedge mclk or posedge reset)
	begin
		if (reset)
			st_q <= '0;
		else
			st_q <= st_d;
	end
	// Storage, no reset needed since pointers guard it
	always_ff @(posedge mclk)
	begin
		if (do_wr)
			mem_q[st_q.wp[AW-1:0]] <= wr_data;
	end
endmodule

/* File: rtl/tx_scan.sv */
// Transmit scan counter stepped by the microcontroller programmed clock.
// Assumes scan_tick is a one-cycle strobe derived from that clock.
`timescale 1ns/1ps
`include "bridge_params.svh"
module tx_scan (
	// Clock and reset
	input wire logic mclk,
	input wire logic reset,
	// Step and enables
	input wire logic scan_tick,
	input wire logic hold,
	input wire logic [7:0] host_en,
	input wire logic [7:0] micro_en,
	// Result
	output logic [3:0] count,
	output logic line_ready
);
	typedef struct packed {
		logic [3:0] cnt;
	} scan_t;
	scan_t st_q, st_d;
	assign count = st_q.cnt;
	// Both enables must agree for the selected line
	assign line_ready = host_en[st_q.cnt[2:0]] && micro_en[st_q.cnt[2:0]];
	// Step only when not holding a pending request for the host
	always_comb
	begin
		st_d = st_q;
		if (scan_tick && !hold)
			st_d.cnt = st_q.cnt + 4'h1;
	end
	always_ff @(posedge mclk or posedge reset)
	begin
		if (reset)
			st_q <= '0;
		else
			st_q <= st_d;
	end
endmodule

/* File: rtl/host_micro_bridge.sv */
// Host bus slave and microcontroller port for the terminal multiplexer bridge.
// Assumes host cycles arrive as one-cycle strobes with address and data stable.
`timescale 1ns/1ps
`include "bridge_params.svh"
// How it works
// - Host address bits 3 to 12 must equal the address switches.
// - Host address bits 13 to 17 must all be ones to respond.
// - Host address bits 1 and 2 select the internal register; bit 0 picks the byte lane.
// - Each cycle is decoded as read, word write or byte write.
// - Receiver interrupts use sub-level A, transmitter sub-level B.
// - First-slot module wins arbitration over the second-slot module.
// - Switch-selected vector is driven on data lines during the dialogue.
// - Host reads go over one internal shared data bus, a source multiplexer.
// - Receive queue is 16 bits wide and 64 entries deep.
// - Micro writes receive entries, host removes them by reading the port.
// - Receive entry: character, 3-bit line, four status flags, one spare.
// - Oldest receive entry is always the one the host reads.
// - Transmit logic requests host characters and tags them with line.
// - Host per-line enable starts and stops transmit requests.
// - Micro per-line enable suspends requests while it has enough data.
// - Line-control queue is 64 entries deep and 24 bits wide.
// - Only the host writes listed next enter the line-control queue.
// - Queued: parameter word writes, control high byte, char/break writes.
// - Control, terminal-ready, ring and carrier stay on host side.
// - Programmable clock steps a 4-bit counter scanning both enables.
// - Counter low three bits are the line, read in status bits 8-10.
// - Alarm counter counts micro writes, flags at 16, clears on host read.
// - Loading a receive entry sets the done bit, requesting receiver interrupt.
// - Transmit interrupt requested when ready and its enable are both set.
module host_micro_bridge (
	// Clock and reset
	input wire logic mclk,
	input wire logic reset,
	// Host bus slave cycle
	input wire logic host_cycle,
	input wire logic [17:0] host_addr,
	input wire logic host_write,
	input wire logic host_byte,
	input wire logic [15:0] host_wdata,
	output logic host_ack,
	output logic [15:0] host_rdata,
	output logic host_data_oe,
	// Configuration switches
	input wire logic [9:0] addr_switch,
	input wire logic [8:0] vector_switch,
	input wire logic slot_first,
	// Interrupt dialogue
	input wire logic grant_in,
	input wire logic other_slot_req,
	output logic req_rx,
	output logic req_tx,
	output logic vector_oe,
	output logic [15:0] vector_data,
	output logic grant_out,
	// Micro receive side
	input wire logic micro_rx_wr,
	input wire logic [15:0] micro_rx_data,
	output logic rx_full,
	output logic rx_empty,
	// Micro line-control side
	input wire logic micro_lc_rd,
	output logic [23:0] micro_lc_data,
	output logic lc_empty,
	output logic lc_full,
	// Micro transmit control
	input wire logic scan_tick,
	input wire logic [7:0] micro_tx_en,
	input wire logic micro_tx_rd,
	output logic [10:0] micro_tx_char,
	output logic micro_tx_valid,
	// Micro modem state word
	input wire logic micro_msw_wr,
	input wire logic [15:0] micro_msw_data
);
	typedef struct packed {
		logic ack;
		logic [15:0] rdata;
		logic data_oe;
		logic req_rx;
		logic req_tx;
		logic vec_oe;
		logic [15:0] vec;
		logic grant_out;
		bridge_pkg::arb_state_t arb;
		logic [15:0] csw;
		logic [7:0] line_transmit_enable_word;
		logic [7:0] dtr;
		logic [15:0] msw;
		logic [4:0] alarm_cnt;
		logic [10:0] tx_char;
		logic tx_valid;
		logic rx_full;
		logic rx_empty;
		logic lc_full;
		logic lc_empty;
	} state_t;
	state_t st_q, st_d;
	bridge_pkg::host_req_t req;
	logic [15:0] rx_head;
	logic rx_empty_w;
	logic rx_full_w;
	logic lc_empty_w;
	logic lc_full_w;
	logic rx_pop;
	logic lc_push;
	logic [23:0] lc_word;
	logic [3:0] scan_cnt;
	logic line_ready;
	logic transmit_ready_flag;
	logic [15:0] ibus;
	// Timing of a host cycle
	// The host strobe is sampled on one edge and every answer is registered,
	// so acknowledge, read data and data enable all appear one clock later
	// and stand for exactly one clock. Back to back cycles are allowed.
	// A read of the receive port pops the queue on the same edge that
	// captures the head, so the host always sees the entry it removed.
	// Hazards worth knowing
	// The flags handed to the micro side are registered copies, one clock
	// behind the queue pointers. A micro writer that pushes on every clock
	// must therefore leave a margin of one entry before full.
	// The queue heads are combinational reads of flip-flop storage; the
	// micro side may sample them in the same clock as its pop strobe.
	// The switches are static levels; no synchroniser is placed on them.
	// Register index sharing
	// Index 4 is the enable word on reads and on writes, where a high byte write is also
	// queued as the transmit control word; index 6 is the modem word on reads and the character port
	// on writes. Index 2 reads the receive port and writes line parameters.
	// The low address bit only picks the byte lane of a byte write.
	// Address decode: switches, all-ones top, low bits select register
	always_comb
	begin
		req.sel = host_cycle && (host_addr[12:3] == addr_switch)
			&& (host_addr[17:13] == `TOP_BITS);
		req.write = host_write;
		req.byte_op = host_write && host_byte;
		req.hi_byte = host_addr[0];
		req.reg_idx = {host_addr[2:1], 1'b0};
		req.wdata = host_wdata;
	end
	assign rx_pop = req.sel && !req.write && (req.reg_idx == `REG_RXPORT);
	// Queue parameter word writes, control high byte and char writes, per source kind
	always_comb
	begin
		lc_push = 1'b0;
		lc_word = {5'h00, req.reg_idx, req.wdata};
		if (req.sel && req.write)
		begin
			unique case (req.reg_idx)
				`REG_CSW: lc_push = 1'b0;
				`REG_RXPORT: lc_push = !req.byte_op;
				`REG_TCW: lc_push = req.byte_op && req.hi_byte;
				`REG_TDW: lc_push = 1'b1;
				default: lc_push = 1'b0;
			endcase
			lc_word = {3'h0, req.byte_op, req.hi_byte, req.reg_idx, req.wdata[15:0]};
		end
	end
	// Receive queue: micro fills, host drains through the port read.
	// Writes while full are dropped inside the queue; the micro must watch
	// rx_full, since no error is flagged back.
	sync_fifo #(.W(`RX_W), .AW(`RX_AW)) rx_fifo (
		.mclk(mclk),
		.reset(reset),
		.wr_en(micro_rx_wr),
		.wr_data(micro_rx_data),
		.rd_en(rx_pop),
		.rd_data(rx_head),
		.empty(rx_empty_w),
		.full(rx_full_w)
	);
	sync_fifo #(.W(`LC_W), .AW(`LC_AW)) lc_fifo (
		.mclk(mclk),
		.reset(reset),
		.wr_en(lc_push),
		.wr_data(lc_word),
		.rd_en(micro_lc_rd),
		.rd_data(micro_lc_data),
		.empty(lc_empty_w),
		.full(lc_full_w)
	);
	// Scan holds while transmit ready stands so the line number stays put
	tx_scan scan (
		.mclk(mclk),
		.reset(reset),
		.scan_tick(scan_tick),
		.hold(st_q.csw[`CSW_TRANSMIT_READY_FLAG_BIT]),
		.host_en(st_q.line_transmit_enable_word),
		.micro_en(micro_tx_en),
		.count(scan_cnt),
		.line_ready(line_ready)
	);
	assign transmit_ready_flag = line_ready && !st_q.tx_valid;
	// Internal shared bus: the one selected source drives it
	always_comb
	begin
		ibus = 16'h0000;
		unique case (req.reg_idx)
			`REG_CSW: ibus = st_q.csw;
			`REG_RXPORT: ibus = rx_empty_w ? 16'h0000 : {1'b1, rx_head[14:0]};
			`REG_TER: ibus = {st_q.dtr, st_q.line_transmit_enable_word};
			`REG_MSW: ibus = st_q.msw;
			default: ibus = 16'h0000;
		endcase
	end
	// Host side state, transmit handoff and interrupt dialogue
	always_comb
	begin
		st_d = st_q;
		st_d.ack = req.sel;
		st_d.data_oe = req.sel && !req.write;
		st_d.rdata = req.sel && !req.write ? ibus : 16'h0000;
		st_d.rx_full = rx_full_w;
		st_d.rx_empty = rx_empty_w;
		st_d.lc_full = lc_full_w;
		st_d.lc_empty = lc_empty_w;
		st_d.csw[10:8] = scan_cnt[2:0];
		// Control word and enables stay local to the host side
		if (req.sel && req.write && req.reg_idx == `REG_CSW)
		begin
			if (!req.byte_op || !req.hi_byte)
				st_d.csw[6:0] = req.wdata[6:0];
			if (!req.byte_op || req.hi_byte)
			begin
				st_d.csw[`CSW_SAE_BIT] = req.wdata[`CSW_SAE_BIT];
				st_d.csw[`CSW_TIE_BIT] = req.wdata[`CSW_TIE_BIT];
			end
		end
		if (req.sel && req.write && req.reg_idx == `REG_TER)
		begin
			if (!req.byte_op || !req.hi_byte)
				st_d.line_transmit_enable_word = req.wdata[7:0];
			if (!req.byte_op || req.hi_byte)
				st_d.dtr = req.wdata[15:8];
		end
		if (micro_msw_wr)
			st_d.msw = micro_msw_data;
		// Alarm counter; a pop clears it, a same-cycle load counts as one
		if (rx_pop)
			st_d.alarm_cnt = (micro_rx_wr && !rx_full_w) ? 5'h01 : 5'h00;
		else if (micro_rx_wr && !rx_full_w && st_q.alarm_cnt != `ALARM_COUNT)
			st_d.alarm_cnt = st_q.alarm_cnt + 5'h01;
		st_d.csw[`CSW_ALARM_BIT] = (st_d.alarm_cnt == `ALARM_COUNT);
		// Done tracks a waiting entry; a new load wins over the pop
		st_d.csw[`CSW_DONE_BIT] = !rx_empty_w || micro_rx_wr;
		// Transmit ready, host write of the char word hands it to the micro
		st_d.csw[`CSW_TRANSMIT_READY_FLAG_BIT] = transmit_ready_flag;
		if (req.sel && req.write && req.reg_idx == `REG_TXPORT && transmit_ready_flag)
		begin
			st_d.tx_char = {scan_cnt[2:0], req.wdata[7:0]};
			st_d.tx_valid = 1'b1;
			st_d.csw[`CSW_TRANSMIT_READY_FLAG_BIT] = 1'b0;
		end
		else if (micro_tx_rd)
			st_d.tx_valid = 1'b0;
		// Receiver request outranks transmitter request
		st_d.req_rx = (st_q.csw[`CSW_DONE_BIT] && st_q.csw[`CSW_RIE_BIT] &&
			(!st_q.csw[`CSW_SAE_BIT] || st_q.csw[`CSW_ALARM_BIT])) && st_q.arb == bridge_pkg::ARB_IDLE;
		st_d.req_tx = st_q.csw[`CSW_TRANSMIT_READY_FLAG_BIT] && st_q.csw[`CSW_TIE_BIT] &&
			st_q.arb == bridge_pkg::ARB_IDLE;
		st_d.vec_oe = 1'b0;
		st_d.grant_out = 1'b0;
		unique case (st_q.arb)
			bridge_pkg::ARB_IDLE:
			begin
				// Second slot defers while the first one requests
				if (grant_in && (slot_first || !other_slot_req))
				begin
					if (st_q.req_rx)
						st_d.arb = bridge_pkg::ARB_RX;
					else if (st_q.req_tx)
						st_d.arb = bridge_pkg::ARB_TX;
					else
						st_d.grant_out = 1'b1;
				end
				else if (grant_in)
					st_d.grant_out = 1'b1;
			end
			bridge_pkg::ARB_RX:
			begin
				st_d.vec_oe = 1'b1;
				st_d.vec = {7'h00, vector_switch};
				st_d.arb = bridge_pkg::ARB_IDLE;
			end
			bridge_pkg::ARB_TX:
			begin
				st_d.vec_oe = 1'b1;
				st_d.vec = {7'h00, vector_switch + `VEC_STEP};
				st_d.arb = bridge_pkg::ARB_IDLE;
			end
		endcase
	end
	always_ff @(posedge mclk or posedge reset)
	begin
		if (reset)
		begin
			st_q <= '0;
			st_q.rx_empty <= 1'b1;
			st_q.lc_empty <= 1'b1;
		end
		else
			st_q <= st_d;
	end
	// Interrupt dialogue
	// A grant that finds a request moves the arbiter to the receive or
	// transmit state; the vector is driven for one clock on the next edge.
	// Requests are masked while the arbiter is busy so that a long grant
	// cannot be answered twice within one dialogue.
	// A grant that finds no request is passed on one clock later, for as long as it stands.
	// The second-slot module lets the grant go by while the first-slot
	// module is requesting, which keeps the first slot ahead.
	// The transmit vector sits two words above the receive vector.
	// Limitation: the vector switches are read live; changing them while a
	// dialogue is in flight yields a mixed vector.
	// Alarm and done
	// The alarm count saturates at sixteen rather than wrapping, so the
	// alarm cannot clear itself while the host falls behind.
	// Done is recomputed every clock from the queue state, so it cannot
	// stick once the host has drained every entry.
	// Transmit handoff
	// The scan stops while ready stands, so the line number read from the
	// control word is the line that the next character will be tagged with.
	// A character written while ready is low is dropped on purpose: the
	// host is expected to poll ready or wait for the interrupt first.
	// Outputs straight from the state register
	assign host_ack = st_q.ack;
	assign host_rdata = st_q.rdata;
	assign host_data_oe = st_q.data_oe;
	assign req_rx = st_q.req_rx;
	assign req_tx = st_q.req_tx;
	assign vector_oe = st_q.vec_oe;
	assign vector_data = st_q.vec;
	assign grant_out = st_q.grant_out;
	assign rx_full = st_q.rx_full;
	assign rx_empty = st_q.rx_empty;
	assign lc_full = st_q.lc_full;
	assign lc_empty = st_q.lc_empty;
	assign micro_tx_char = st_q.tx_char;
	assign micro_tx_valid = st_q.tx_valid;
endmodule

/* File: bench/host_micro_bridge_sva.sv */
// Checker for the bridge top: host decode, vector dialogue, queue and transmit flags.
// Assumes one mclk domain; sees only the top module ports.
`timescale 1ns/1ps
module host_micro_bridge_sva (
	// Host side and switches
	input wire logic mclk, reset, host_cycle, host_write, host_byte, host_ack, host_data_oe,
	input wire logic [17:0] host_addr,
	input wire logic [15:0] host_wdata, host_rdata, vector_data, micro_rx_data, micro_msw_data,
	input wire logic [9:0] addr_switch,
	input wire logic [8:0] vector_switch,
	// Interrupt dialogue and micro side
	input wire logic slot_first, grant_in, other_slot_req, req_rx, req_tx, vector_oe, grant_out,
	input wire logic micro_rx_wr, rx_full, rx_empty, micro_lc_rd, lc_empty, lc_full, scan_tick,
	input wire logic micro_tx_rd, micro_tx_valid, micro_msw_wr,
	input wire logic [23:0] micro_lc_data,
	input wire logic [7:0] micro_tx_en,
	input wire logic [10:0] micro_tx_char
);
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (reset);
	// A cycle this module answers
	sequence s_sel;
		host_cycle && host_addr[17:13] == 5'h1f && host_addr[12:3] == addr_switch;
	endsequence
	// Word write of the parameter slot while there is room
	sequence s_lc_wr;
		s_sel ##0 (host_write && !host_byte && host_addr[2:1] == 2'h1 && !lc_full);
	endsequence
	// Grant rising on a pending request
	sequence s_grant;
		$rose(grant_in) && (req_rx || req_tx) && !other_slot_req;
	endsequence
	a_sel_ack: assert property (s_sel |=> host_ack)
		else $error("selected cycle not answered");
	a_top_miss: assert property (host_cycle && host_addr[17:13] != 5'h1f |=> !host_ack)
		else $error("foreign address answered");
	a_ack_kind: assert property (
		host_ack || host_data_oe |-> $past(host_cycle) && host_data_oe == !$past(host_write))
		else $error("answer kind wrong");
	a_lc_push: assert property (s_lc_wr |-> ##[1:3] !lc_empty)
		else $error("parameter write not queued");
	a_rx_load: assert property (micro_rx_wr && !rx_full |-> ##[1:2] !rx_empty)
		else $error("receive load lost");
	a_vec_after: assert property (s_grant |-> ##2 vector_oe)
		else $error("no vector after grant");
	a_vec_pulse: assert property (vector_oe |=> !vector_oe)
		else $error("vector drive too long");
	a_vec_prio: assert property (
		vector_oe |-> vector_data[8:0] == ($past(req_rx, 2) ? vector_switch : vector_switch + 9'h004))
		else $error("vector level wrong");
	a_pass_on: assert property (grant_out |-> $past(grant_in) && !$past(req_rx) && !$past(req_tx))
		else $error("grant passed while requesting");
	a_tx_hold: assert property (
		micro_tx_valid && !micro_tx_rd |=> micro_tx_valid && $stable(micro_tx_char))
		else $error("transmit char not held");
	a_tx_take: assert property (micro_tx_valid && micro_tx_rd |=> !micro_tx_valid)
		else $error("transmit char not taken");
endmodule
bind host_micro_bridge host_micro_bridge_sva chk (.*);

/* File: bench/host_cpu_model.sv */
// Host processor model: single bus cycles at the bridge slave port.
// Assumes a free running mclk and an answer one clock after a taken cycle.
`timescale 1ns/1ps
module host_cpu_model (
	// Clock and answer
	input wire logic mclk,
	input wire logic host_ack,
	input wire logic [15:0] host_rdata,
	// Cycle request
	output logic host_cycle,
	output logic host_addr_unused_never,
	output logic [17:0] host_addr,
	output logic host_write,
	output logic host_byte,
	output logic [15:0] host_wdata
);
	// Idle bus at time zero
	initial
	begin
		host_cycle = 1'b0;
		host_addr_unused_never = 1'b0;
		host_addr = 18'h0;
		host_write = 1'b0;
		host_byte = 1'b0;
		host_wdata = 16'h0;
	end
	// Strobe one clock, take the answer while it stands, then scramble released lines
	task automatic cycle(input logic w, input logic b, input logic [17:0] a,
		input logic [15:0] d, output logic [15:0] q, output logic ok);
		@(negedge mclk);
		host_cycle = 1'b1;
		host_write = w;
		host_byte = b;
		host_addr = a;
		host_wdata = d;
		@(negedge mclk);
		host_cycle = 1'b0;
		ok = host_ack;
		q = host_rdata;
		@(negedge mclk);
		host_addr = ~a; // Released lines must not look like the last value
		host_wdata = ~d;
		host_write = ~w;
		host_byte = ~b;
	endtask
endmodule

/* File: bench/host_micro_bridge_tb_top.sv */
// Bench top: host model cycles, micro side strobes and vector dialogue checks.
// Assumes host_cpu_model.sv and the bound checker are compiled first.
`timescale 1ns/1ps
module host_micro_bridge_tb_top;
	localparam logic [9:0] base_sw = 10'h001; // Base at the low end of the floating range
	localparam logic [8:0] vec_sw = 9'h0c0;
	logic mclk, reset, host_cycle, host_write, host_byte, host_ack, host_data_oe, ok, gp;
	logic scan_tick = 1'b0;
	logic slot_first, grant_in, other_slot_req, req_rx, req_tx, vector_oe, grant_out;
	logic micro_rx_wr, rx_full, rx_empty, micro_lc_rd, lc_empty, lc_full;
	logic micro_tx_rd, micro_tx_valid, micro_msw_wr;
	logic [17:0] host_addr;
	logic [15:0] host_wdata, host_rdata, vector_data, micro_rx_data, micro_msw_data, q;
	logic [9:0] addr_switch;
	logic [8:0] vector_switch, v;
	logic [23:0] micro_lc_data;
	logic [23:0] lc_exp [3] = '{24'h021234, 24'h1cab00, 24'h160077};
	logic [7:0] micro_tx_en;
	logic [10:0] micro_tx_char;
	logic [2:0] tick_cnt = 3'h0;
	int fail_count = 0;
	int tests_run = 0;
	int i;
	// Design and host model meet on the bus signals by name
	host_micro_bridge uut (.*);
	host_cpu_model host (.host_addr_unused_never(), .*);
	always #2.5 mclk = ~mclk;
	// Scan clock from the micro side, one strobe per eight clocks
	always @(negedge mclk)
	begin
		tick_cnt <= tick_cnt + 3'h1;
		scan_tick <= tick_cnt == 3'h0;
	end
	task automatic check(input logic [23:0] seen, input logic [23:0] exp, input string what);
		tests_run++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("MISMATCH at %0t: %s", $time, what);
		end
	endtask
	// One answered host cycle to register slot i
	task automatic acc(input logic w, input logic b, input logic [2:0] i, input logic [15:0] d);
		host.cycle(w, b, {5'h1f, base_sw, i}, d, q, ok);
		check(24'(ok), 24'h1, "host cycle not answered");
	endtask
	// Grant for two clocks, as the host drops it once answered; a longer
	// grant would see the masked request and pass the grant on
	task automatic grant(input logic [8:0] exp, input logic pass);
		grant_in = 1'b1;
		v = 9'h0;
		gp = 1'b0;
		repeat (2)
		begin
			@(negedge mclk);
			if (vector_oe === 1'b1)
				v = vector_data[8:0];
			gp = gp | grant_out;
		end
		grant_in = 1'b0;
		check(24'({gp, v}), 24'({pass, exp}), "interrupt dialogue");
	endtask
	// Let the scan run ten steps, then read the control word
	task automatic scan_rd();
		repeat (80) @(negedge mclk);
		acc(1'b0, 1'b0, 3'h0, 16'h0);
	endtask
	task automatic end_of_test();
		$display("comparisons %0d, mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// Hang guard: the sequence needs about 430 clocks
	initial
	begin
		repeat (20000) @(posedge mclk);
		fail_count++;
		end_of_test();
	end
	initial
	begin
		{mclk, reset, grant_in, other_slot_req} = 4'h4;
		{micro_rx_wr, micro_lc_rd, micro_tx_rd, micro_msw_wr, micro_tx_en} = 12'h0;
		{micro_rx_data, micro_msw_data} = 32'h0;
		slot_first = 1'b1;
		addr_switch = base_sw;
		vector_switch = vec_sw;
		repeat (6) @(posedge mclk);
		@(negedge mclk);
		reset = 1'b0;
		check(24'({rx_empty, lc_empty, req_rx, req_tx, host_ack}), 24'h18, "reset");
		// Decode: foreign top bits or switches get no answer; modem word reads back
		host.cycle(1'b0, 1'b0, {5'h1e, base_sw, 3'h0}, 16'h0, q, ok);
		check(24'(ok), 24'h0, "foreign top bits answered");
		host.cycle(1'b0, 1'b0, {5'h1f, ~base_sw, 3'h0}, 16'h0, q, ok);
		check(24'(ok), 24'h0, "foreign switch answered");
		micro_msw_wr = 1'b1;
		micro_msw_data = 16'h5a00;
		@(negedge mclk);
		micro_msw_wr = 1'b0;
		acc(1'b0, 1'b0, 3'h6, 16'h0);
		check(24'(q), 24'h5a00, "modem word");
		$display("test decode done");
		// Only parameter words, control high byte and char writes are queued
		acc(1'b1, 1'b0, 3'h2, 16'h1234);
		acc(1'b1, 1'b1, 3'h5, 16'hab00);
		acc(1'b1, 1'b1, 3'h6, 16'h0077);
		acc(1'b1, 1'b0, 3'h0, 16'h0000);
		acc(1'b1, 1'b0, 3'h4, 16'h0000);
		acc(1'b1, 1'b1, 3'h2, 16'h0099);
		for (i = 0; i < 3; i++)
		begin
			check(micro_lc_data, lc_exp[i], "line control entry");
			micro_lc_rd = 1'b1;
			@(negedge mclk);
			micro_lc_rd = 1'b0;
			repeat (2) @(negedge mclk);
		end
		check(24'(lc_empty), 24'h1, "line control drained");
		$display("test line control done");
		// Receive: sixteen loads raise the alarm, reads come oldest first
		acc(1'b1, 1'b0, 3'h0, 16'h4040);
		grant(9'h0, 1'b1);
		for (i = 0; i < 16; i++)
		begin
			micro_rx_wr = 1'b1;
			micro_rx_data = {1'b0, 4'(i), 3'(i), 8'(i)};
			@(negedge mclk);
		end
		micro_rx_wr = 1'b0;
		repeat (2) @(negedge mclk);
		acc(1'b0, 1'b0, 3'h0, 16'h0);
		check(24'(q & 16'h2080), 24'h2080, "done and alarm");
		grant(vec_sw, 1'b0);
		for (i = 0; i < 16; i++)
		begin
			acc(1'b0, 1'b0, 3'h2, 16'h0);
			check(24'(q), 24'({1'b1, 4'(i), 3'(i), 8'(i)}), "receive entry");
			acc(1'b0, 1'b0, 3'h0, 16'h0);
			check(24'(q[13]), 24'h0, "alarm after read");
		end
		acc(1'b0, 1'b0, 3'h2, 16'h0);
		check(24'(q), 24'h0, "empty receive port");
		$display("test receive done");
		// Transmit: only line 3 enabled on both sides
		micro_tx_en = 8'h08;
		acc(1'b1, 1'b0, 3'h4, 16'h0008);
		scan_rd();
		check(24'(q[15:8]), 24'hc3, "ready on line 3");
		grant(vec_sw + 9'h004, 1'b0);
		acc(1'b1, 1'b0, 3'h6, 16'h0041);
		@(negedge mclk);
		check(24'({micro_tx_valid, micro_tx_char}), 24'h00b41, "char to micro");
		micro_tx_rd = 1'b1;
		@(negedge mclk);
		micro_tx_rd = 1'b0;
		micro_tx_en = 8'hf7;
		scan_rd();
		check(24'(q[15]), 24'h0, "micro hold");
		micro_tx_en = 8'hff;
		acc(1'b1, 1'b0, 3'h4, 16'h0000);
		scan_rd();
		check(24'(q[15]), 24'h0, "host stop");
		$display("test transmit done");
		end_of_test();
	end
endmodule
